// ==== core/see_eeprom_slave.v ====
// Purpose: SPI slave front end of a 1024-byte serial EEPROM with array
// Assumes: Serial pins asynchronous to ref_clk, serial clock well below ref_clk/8
// Notes:   Page write bytes pass an 8-word FIFO before the self-timed commit
`timescale 1ns/1ps
`include "see_consts.vh"
module see_eeprom_slave #(
  parameter TWC_CYCLES = `SEE_TWC_CYCLES,
  parameter PAGE_BYTES = `SEE_PAGE_BYTES
) (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire chipSel_b,
  input  wire serClk,
  input  wire serIn,
  output wire serOut,
  output wire serOutEn,
  input  wire protectPin_b,
  input  wire pause_b
);
  localparam PW = (PAGE_BYTES == 32) ? 5 : 4;   // Column bits in a page
  // Column mask inside a page, at the address width so no bits drop
  localparam [9:0] PAGE_MASK = (PAGE_BYTES == 32) ? 10'h01f : 10'h00f;

  // Frame states, one-hot
  localparam ST_INSTR = 5'b00001;
  localparam ST_ADDR  = 5'b00010;
  localparam ST_DATA  = 5'b00100;
  localparam ST_OUT   = 5'b01000;
  localparam ST_IGN   = 5'b10000;

  // Synchronised pins
  // Every pin crosses two flops before any logic sees it
  // Serial clock edges are found in ref_clk, two to three cycles late
  // Select and pause reset high so no false frame follows reset
  // Limitation: serial clock must stay well below an eighth of ref_clk
  // Data and clock share the same delay, so setup is kept
  wire csB;
  wire sck;
  wire sdi;
  wire wpB;
  wire holdB;

  see_sync #(.RST_VAL(1'b1)) uSyncCs   (.ref_clk(ref_clk), .rst_b(rst_b), .asyncIn(chipSel_b),    .syncOut(csB));
  see_sync #(.RST_VAL(1'b0)) uSyncSck  (.ref_clk(ref_clk), .rst_b(rst_b), .asyncIn(serClk),       .syncOut(sck));
  see_sync #(.RST_VAL(1'b0)) uSyncSi   (.ref_clk(ref_clk), .rst_b(rst_b), .asyncIn(serIn),        .syncOut(sdi));
  see_sync #(.RST_VAL(1'b1)) uSyncWp   (.ref_clk(ref_clk), .rst_b(rst_b), .asyncIn(protectPin_b), .syncOut(wpB));
  see_sync #(.RST_VAL(1'b1)) uSyncHold (.ref_clk(ref_clk), .rst_b(rst_b), .asyncIn(pause_b),      .syncOut(holdB));

  reg        sckPrev_q;                  // Last synchronised serial clock
  reg        csPrev_q;                   // Last synchronised select
  reg        paused_q;                   // Pause in force
  reg [4:0]  state_q;                    // Frame state
  reg [2:0]  bitCnt_q;                   // Bit index in current byte
  reg [7:0]  shift_q;                    // Input shift register
  reg [7:0]  instr_q;                    // Instruction register
  reg        addrHi_q;                   // High (first) address byte pending
  reg [9:0]  addr_q;                     // Array address pointer
  reg [7:0]  outSh_q;                    // Output shift register
  reg        outBit_q;                   // Driven output bit
  reg        byteDone_q;                 // Last data byte ended on D0
  reg [7:0]  statData_q;                 // Byte captured for status write
  reg        wel_q;                      // Write enable latch
  reg [2:0]  nv_q;                       // Protect-enable, block-protect hi, lo
  reg        busy_q;                     // Internal write in progress
  reg [31:0] twc_q;                      // Write cycle timer
  reg        commitArr_q;                // Committing array page
  reg        commitSt_q;                 // Committing status byte
  reg [9:0]  pageBase_q;                 // Page base for commit
  reg [PW-1:0] col_q;                    // Commit column
  reg [7:0]  mem [0:1023];               // Array storage
  reg        oneByte_q;                  // Only the instruction byte seen so far
  reg        drive_q;                    // Output bit has been presented

  wire sckRise = sck && !sckPrev_q;      // Edge events in ref_clk
  wire sckFall = !sck && sckPrev_q;
  wire csRise  = csB && !csPrev_q;
  wire active  = !csB && !paused_q;
  wire [7:0] shNext = {shift_q[6:0], sdi};
  wire [7:0] status = {nv_q[2], 3'b000, nv_q[1], nv_q[0], wel_q, busy_q};
  wire hwProt  = !wpB && nv_q[2];

  // Frame-end events; each needs the select rise right after a whole byte
  wire frameEnd   = csRise && byteDone_q;
  // Latch commands count only when nothing followed the instruction byte
  wire latchSetEv = frameEnd && oneByte_q && state_q == ST_IGN
                    && instr_q == `SEE_INSTR_LATCH_SET;
  wire latchClrEv = frameEnd && oneByte_q && state_q == ST_IGN
                    && instr_q == `SEE_INSTR_LATCH_CLR;
  // An array write that will really be committed
  wire arrCommit  = frameEnd && wel_q && !busy_q && state_q == ST_DATA
                    && instr_q == `SEE_INSTR_WRITE;
  // Any other select rise drops what the FIFO holds, unless a commit drains it;
  // otherwise a refused write would leave bytes for the next commit to pick up
  wire fifoFlush  = csRise && !arrCommit && !commitArr_q;

  // FIFO carrying page data to the commit engine
  // Bytes are pushed as their last bit arrives, before the frame ends
  // Only eight are held; a longer burst loses the later bytes
  // Trade-off: small buffer instead of a full page latch
  // Popped one per cycle once the commit starts
  wire       fInReady;
  wire       fOutValid;
  wire [7:0] fOutData;
  wire       fPush = active && sckRise && (state_q == ST_DATA) && (bitCnt_q == 3'd7)
                     && (instr_q == `SEE_INSTR_WRITE);
  wire       fPop  = commitArr_q && fOutValid;

  see_fifo #(.WIDTH(`SEE_FIFO_W), .DEPTH(`SEE_FIFO_D), .AW(3)) uFifo (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .flush   (fifoFlush),
    .inValid (fPush),
    .inReady (fInReady),
    .inData  (shNext),
    .outValid(fOutValid),
    .outReady(commitArr_q),
    .outData (fOutData)
  );

  // Block-protect range check for an address
  function prot;
    input [9:0] a;
    input [1:0] bp;
    begin
      case (bp)
        2'b01:   prot = (a >= `SEE_PROT_QTR);
        2'b10:   prot = (a >= `SEE_PROT_HALF);
        2'b11:   prot = 1'b1;
        default: prot = 1'b0;
      endcase
    end
  endfunction

  // Pause: entered and left only while serial clock is low
  // A request with the clock high waits for the clock to fall
  // Select high always ends the pause with the frame
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      paused_q <= 1'b0;
    end else if (csB) begin
      paused_q <= 1'b0;
    end else if (!sck) begin
      paused_q <= !holdB;
    end
  end

  // Serial front end: shift, decode, address, data out
  // One rising edge moves one bit; eight make a byte
  // Instruction byte picks the path through the frame states
  // Read and write are refused while the write cycle runs
  // Refused frames sit in the ignore state until select rises
  // Status read reloads the status byte after every byte
  // Array read reloads from the pointer and steps it
  // Pointer wraps at the top of the array by its width
  // Output bit moves only after a falling edge
  // Deselect restarts the sequence; instruction, pointer and byteDone_q keep their values
  // Hazard: a frame cut mid-byte leaves byteDone low
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sckPrev_q  <= 1'b0;
      csPrev_q   <= 1'b1;
      state_q    <= ST_INSTR;
      bitCnt_q   <= 3'd0;
      shift_q    <= 8'h00;
      instr_q    <= 8'h00;
      addrHi_q   <= 1'b0;
      addr_q     <= `SEE_ADDR_ZERO;
      outSh_q    <= 8'h00;
      outBit_q   <= 1'b0;
      byteDone_q <= 1'b0;
      statData_q <= 8'h00;
      oneByte_q  <= 1'b0;
      drive_q    <= 1'b0;
    end else begin
      sckPrev_q <= sck;
      csPrev_q  <= csB;
      if (csB) begin
        // Deselected: sequence restarts at next select fall
        state_q  <= ST_INSTR;
        bitCnt_q <= 3'd0;
        addrHi_q <= 1'b0;
        oneByte_q <= 1'b1;
        drive_q  <= 1'b0;
      end else if (active && sckRise) begin
        shift_q    <= shNext;
        bitCnt_q   <= bitCnt_q + 3'd1;
        byteDone_q <= (bitCnt_q == 3'd7);
        if (bitCnt_q == 3'd7) begin
          // Cleared by any byte after the instruction byte
          oneByte_q <= (state_q == ST_INSTR);
          case (state_q)
            ST_INSTR: begin
              instr_q <= shNext;
              case (shNext)
                `SEE_INSTR_READ:    state_q <= busy_q ? ST_IGN : ST_ADDR;
                `SEE_INSTR_WRITE:   state_q <= busy_q ? ST_IGN : ST_ADDR;
                `SEE_INSTR_STAT_RD: begin
                  state_q <= ST_OUT;
                  outSh_q <= status;
                end
                `SEE_INSTR_STAT_WR: state_q <= ST_DATA;
                default:            state_q <= ST_IGN;
              endcase
              addrHi_q <= 1'b1;
            end
            ST_ADDR: begin
              if (addrHi_q) begin
                addr_q[9:8] <= shNext[1:0];
                addrHi_q    <= 1'b0;
              end else begin
                addr_q[7:0] <= shNext;
                if (instr_q == `SEE_INSTR_READ) begin
                  state_q <= ST_OUT;
                  outSh_q <= mem[{addr_q[9:8], shNext}];
                  addr_q  <= {addr_q[9:8], shNext} + 10'd1;
                end else begin
                  state_q <= ST_DATA;
                end
              end
            end
            ST_DATA: begin
              statData_q <= shNext;
            end
            ST_OUT: begin
              if (instr_q == `SEE_INSTR_READ) begin
                outSh_q <= mem[addr_q];
                addr_q  <= addr_q + 10'd1;
              end else begin
                outSh_q <= status;
              end
            end
            default: state_q <= ST_IGN;
          endcase
        end
      end else if (active && sckFall && state_q == ST_OUT) begin
        // Present next bit after the falling edge
        outBit_q <= outSh_q[~bitCnt_q];
        drive_q  <= 1'b1;
      end
    end
  end

  // Data output floats when deselected or paused
  // Enable waits for the first falling edge, so a stale bit
  // from the previous frame is never driven while the clock is high
  assign serOut   = outBit_q;
  assign serOutEn = active && drive_q;

  // Latch, status bits and the self-timed write cycle
  // Latch commands act at the select rise ending their frame
  // Writes need the latch, an idle engine and a whole last byte
  // Status write is dropped by the protect pin and enable bit
  // The cycle timer counts system clocks, not real time
  // Busy stands for exactly the configured count
  // Latch clears on the clear command or when a commit finishes
  // Nonvolatile bits change at the end of the cycle
  // Limitation: no power-loss model, bits live in flops
  // A set command in the finishing cycle wins over the clear
  wire wrValid = csRise && byteDone_q && wel_q && !busy_q;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wel_q       <= 1'b0;
      nv_q        <= `SEE_NV_RESET;
      busy_q      <= 1'b0;
      twc_q       <= 32'd0;
      commitArr_q <= 1'b0;
      commitSt_q  <= 1'b0;
      pageBase_q  <= `SEE_ADDR_ZERO;
      col_q       <= {PW{1'b0}};
    end else begin
      if (latchSetEv) begin
        wel_q <= 1'b1;
      end else if (latchClrEv) begin
        wel_q <= 1'b0;
      end
      if (wrValid && state_q == ST_DATA && instr_q == `SEE_INSTR_WRITE) begin
        busy_q      <= 1'b1;
        commitArr_q <= 1'b1;
        twc_q       <= 32'd0;
        pageBase_q  <= addr_q & ~PAGE_MASK;
        col_q       <= addr_q[PW-1:0];
      end else if (wrValid && state_q == ST_DATA && instr_q == `SEE_INSTR_STAT_WR && !hwProt) begin
        busy_q     <= 1'b1;
        commitSt_q <= 1'b1;
        twc_q      <= 32'd0;
      end else if (busy_q) begin
        twc_q <= twc_q + 32'd1;
        if (twc_q == TWC_CYCLES - 1) begin
          busy_q      <= 1'b0;
          // Set landing in this very cycle keeps the latch
          if (!latchSetEv) begin
            wel_q <= 1'b0;
          end
          commitArr_q <= 1'b0;
          commitSt_q  <= 1'b0;
          if (commitSt_q) begin
            nv_q <= {statData_q[`SEE_ST_PEN], statData_q[`SEE_ST_BP_HI], statData_q[`SEE_ST_BP_LO]};
          end
        end
        if (fPop) begin
          col_q <= col_q + 1'b1;
        end
      end
    end
  end

  // Array commit, one byte per cycle from the FIFO, protected range skipped
  // Column wraps inside the page, never into the next one
  // Protection is judged per byte, so a page may land in part
  // Array storage has no reset; content survives rst_b
  // Hazard: protect bits read at commit, not at frame end
  // Both are the same here since status writes need the engine idle
  always @(posedge ref_clk) begin
    if (fPop && !prot(pageBase_q | {{(10-PW){1'b0}}, col_q}, nv_q[1:0])) begin
      mem[pageBase_q | {{(10-PW){1'b0}}, col_q}] <= fOutData;
    end
  end
endmodule

// ==== include/see_consts.vh ====
// Purpose: Constants for the serial EEPROM slave front end
// Assumes: 250 MHz system clock (4 ns period)
// Notes:   Instruction codes, status fields, array and timing figures
`ifndef SEE_CONSTS_VH
`define SEE_CONSTS_VH

// Instruction codes
`define SEE_INSTR_READ        8'h03
`define SEE_INSTR_WRITE       8'h02
`define SEE_INSTR_LATCH_CLR   8'h04
`define SEE_INSTR_LATCH_SET   8'h06
`define SEE_INSTR_STAT_RD     8'h05
`define SEE_INSTR_STAT_WR     8'h01

// Status register field positions
`define SEE_ST_BUSY           0
`define SEE_ST_WEL            1
`define SEE_ST_BP_LO          2
`define SEE_ST_BP_HI          3
`define SEE_ST_PEN            7

// Reset value of the nonvolatile status bits
`define SEE_NV_RESET          3'h0

// Array geometry
`define SEE_ADDR_W            10
`define SEE_ADDR_TOP          10'h3ff
`define SEE_ADDR_ZERO         10'h000
`define SEE_PROT_QTR          10'h300
`define SEE_PROT_HALF         10'h200
`define SEE_PAGE_BYTES        32

// Internal write time, printed in ms, and its cycle count
`define SEE_TWC_MS            5
`define SEE_CLK_MHZ           250
`define SEE_TWC_CYCLES        (`SEE_TWC_MS * 1000 * `SEE_CLK_MHZ)

// Data FIFO shape
`define SEE_FIFO_W            8
`define SEE_FIFO_D            8

`endif

// ==== core/see_sync.v ====
// Purpose: Two-flop synchroniser for pins entering the ref_clk domain
// Assumes: Input is asynchronous to ref_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module see_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire asyncIn,
  output wire syncOut
);
  reg meta_q;   // First stage, may go metastable
  reg sync_q;   // Second stage, safe to use

  // Two stages; reset to a chosen idle level
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule

// ==== core/see_fifo.v ====
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
module see_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage
  reg [AW:0]      wrPtr_q;           // Write pointer with wrap bit
  reg [AW:0]      rdPtr_q;           // Read pointer with wrap bit

  wire full  = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  wire empty = (wrPtr_q == rdPtr_q);
  wire doWr  = inValid && !full;
  wire doRd  = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  // Storage writes; no reset needed on data
  always @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // Pointers; flush drops everything
  always @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// ==== tb/see_host_model.sv ====
// Purpose: Host SPI master model for the serial EEPROM slave
// Assumes: Mode 0, 64 ns serial period, pull-up on the data-out wire
// Notes:   Serial clock stands low between frames
`timescale 1ns/1ps
module see_host_model (
  input  wire  ref_clk,
  input  wire  serOut,
  input  wire  serOutEn,
  output logic chipSel_b,
  output logic serClk,
  output logic serIn,
  output logic pause_b
);
  wire soWire = serOutEn ? serOut : 1'b1; // Pulled up when released
  // Idle pins
  initial begin
    chipSel_b = 1'b1;
    serClk    = 1'b0;
    serIn     = 1'b0;
    pause_b   = 1'b1;
  end
  // Half a serial period, always 1 ns after a system edge
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  // Select the device
  task automatic start();
    chipSel_b = 1'b0;
    half();
  endtask
  // One byte MSB first; pause before bit pb, clock pulse ignored inside
  task automatic xfer(input logic [7:0] tx, input int pb, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == pb) begin
        pause_b = 1'b0;
        half();
        serClk = 1'b1;
        serIn  = ~serIn;
        half();
        serClk = 1'b0;
        half();
        pause_b = 1'b1;
        half();
      end
      serIn = tx[i];
      half();
      serClk = 1'b1;
      rx = {rx[6:0], soWire};
      half();
      serClk = 1'b0;
    end
  endtask
  // Extra stray bits abort a write; then deselect
  task automatic stop(input int extra);
    repeat (extra) begin
      serIn = 1'b1;
      half();
      serClk = 1'b1;
      half();
      serClk = 1'b0;
    end
    half();
    chipSel_b = 1'b1;
    serIn     = ~serIn; // Stale data not held
    half();
    half();
  endtask
endmodule

// ==== tb/see_eeprom_slave_chk.sv ====
// Purpose: Port-level checker for the serial EEPROM slave
// Assumes: Serial pins sampled raw on ref_clk
// Notes:   Raw edges lead the design by its synchroniser delay
`timescale 1ns/1ps
`include "see_consts.vh"
module see_eeprom_slave_chk #(
  parameter TWC_CYCLES = 2000,
  parameter PAGE_BYTES = 32
) (
  input wire ref_clk,
  input wire rst_b,
  input wire chipSel_b,
  input wire serClk,
  input wire serIn,
  input wire serOut,
  input wire serOutEn,
  input wire protectPin_b,
  input wire pause_b
);
  logic       clkDly_q;  // Serial clock one cycle late
  logic [5:0] riseCnt_q; // Unpaused rising edges this frame
  logic [7:0] instr_q;   // First byte of the frame
  wire        rise = serClk && !clkDly_q && pause_b;
  // Count bits per frame; saturate so long reads never wrap
  always @(posedge ref_clk) begin
    clkDly_q <= serClk;
    if (!rst_b || chipSel_b) begin
      riseCnt_q <= 6'h00;
      instr_q   <= 8'h00;
    end else if (rise && riseCnt_q != 6'h3f) begin
      riseCnt_q <= riseCnt_q + 6'h01;
      if (riseCnt_q < 6'h08)
        instr_q <= {instr_q[6:0], serIn};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Output held through a clock-high phase
  sequence outHeld;
    (serClk && serOutEn)[*6] ##1 (serClk && serOutEn);
  endsequence
  sequence enStart;
    $rose(serOutEn);
  endsequence
  sel_off_a: assert property (chipSel_b[*6] |-> !serOutEn)
    else $error("output driven while deselected");
  read_end_a: assert property ($rose(chipSel_b) |-> ##[1:6] !serOutEn)
    else $error("output not released after select rise");
  pause_off_a: assert property (!pause_b[*6] |-> !serOutEn)
    else $error("output driven while paused");
  out_stable_a: assert property (outHeld |-> $stable(serOut))
    else $error("data out moved while serial clock high");
  change_low_a: assert property (serOutEn && $changed(serOut) |-> !serClk)
    else $error("data out changed outside clock low");
  en_rise_a: assert property (enStart |-> !serClk && pause_b && !chipSel_b)
    else $error("output enabled at wrong moment");
  instr_len_a: assert property (enStart |-> riseCnt_q >= 6'h08)
    else $error("output before full instruction");
  read_len_a: assert property (enStart and (instr_q == `SEE_INSTR_READ) |-> riseCnt_q >= 6'h18)
    else $error("read data before full address");
endmodule
bind see_eeprom_slave see_eeprom_slave_chk #(.TWC_CYCLES(TWC_CYCLES), .PAGE_BYTES(PAGE_BYTES)) chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .chipSel_b(chipSel_b), .serClk(serClk), .serIn(serIn),
  .serOut(serOut), .serOutEn(serOutEn), .protectPin_b(protectPin_b), .pause_b(pause_b));

// ==== tb/see_eeprom_slave_tb_top.sv ====
// Purpose: Self-checking bench for the serial EEPROM slave
// Assumes: Short write cycle of 2000 system clocks
// Notes:   Array is not reset, so only written bytes are compared
`timescale 1ns/1ps
module see_eeprom_slave_tb_top;
  logic       ref_clk;         // System clock
  logic       rst_b;           // Synchronous reset
  logic       protectPin_b;    // Write-protect pin
  wire        chipSel_b;       // Host-driven pins
  wire        serClk;
  wire        serIn;
  wire        pause_b;
  wire        serOut;          // Device outputs
  wire        serOutEn;
  logic [7:0] rx;              // Last byte heard
  int         miscompares;     // Mismatches
  int         samples_checked; // Comparisons
  see_eeprom_slave #(.TWC_CYCLES(2000)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .chipSel_b(chipSel_b), .serClk(serClk), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn),
    .protectPin_b(protectPin_b), .pause_b(pause_b));
  see_host_model host (.ref_clk(ref_clk), .serOut(serOut), .serOutEn(serOutEn), .chipSel_b(chipSel_b),
    .serClk(serClk), .serIn(serIn), .pause_b(pause_b));
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
      miscompares++;
    if (got !== exp)
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
  endtask
  // One-byte command frame
  task automatic cmd(input logic [7:0] c);
    host.start();
    host.xfer(c, 9, rx);
    host.stop(0);
  endtask
  task automatic status(input logic [7:0] exp);
    host.start();
    host.xfer(8'h05, 9, rx);
    host.xfer(8'h00, 9, rx);
    host.stop(0);
    chk(rx, exp);
  endtask
  // Two-byte read, optional pause inside the first data byte
  task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1, input int pb);
    host.start();
    host.xfer(8'h03, 9, rx);
    host.xfer(a[15:8], 9, rx);
    host.xfer(a[7:0], 9, rx);
    host.xfer(8'h00, pb, rx);
    chk(rx, e0);
    host.xfer(8'h00, 9, rx);
    chk(rx, e1);
    host.stop(0);
  endtask
  // Latch set, then a two-byte write frame
  task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1, input int extra);
    cmd(8'h06);
    host.start();
    host.xfer(8'h02, 9, rx);
    host.xfer(a[15:8], 9, rx);
    host.xfer(a[7:0], 9, rx);
    host.xfer(d0, 9, rx);
    host.xfer(d1, 9, rx);
    host.stop(extra);
  endtask
  task automatic sw(input logic [7:0] d);
    cmd(8'h06);
    host.start();
    host.xfer(8'h01, 9, rx);
    host.xfer(d, 9, rx);
    host.stop(0);
  endtask
  // Poll the busy bit under a bound
  task automatic waitIdle();
    for (int n = 0; n < 30; n++) begin
      host.start();
      host.xfer(8'h05, 9, rx);
      host.xfer(8'h00, 9, rx);
      host.stop(0);
      if (rx[0] === 1'b0)
        return;
    end
    miscompares++;
    $display("unexpected at %0t: busy never cleared", $time);
  endtask
  task automatic latchCmds();
    status(8'h00);
    cmd(8'h06);
    status(8'h02);
    cmd(8'h04);
    status(8'h00);
  endtask
  // Page wrap, busy refusal, rollover and pause
  task automatic pageWrite();
    wr(16'h001f, 8'h11, 8'h22, 0);
    status(8'h03);
    rd(16'h0000, 8'hff, 8'hff, 9);
    waitIdle();
    status(8'h00);
    wr(16'h03ff, 8'h33, 8'h44, 0);
    waitIdle();
    wr(16'h0001, 8'h55, 8'h66, 0);
    waitIdle();
    rd(16'hffff, 8'h33, 8'h22, 9);
    rd(16'h0000, 8'h22, 8'h55, 3);
  endtask
  // Latch without select rise, then an aborted write
  task automatic aborts();
    host.start();
    host.xfer(8'h06, 9, rx);
    host.xfer(8'h02, 9, rx);
    host.xfer(8'h00, 9, rx);
    host.xfer(8'h01, 9, rx);
    host.xfer(8'h99, 9, rx);
    host.stop(0);
    status(8'h00);
    wr(16'h0001, 8'h77, 8'h88, 3);
    status(8'h02);
    cmd(8'h04);
    rd(16'h0001, 8'h55, 8'h66, 9);
  endtask
  // Block protect and hardware protect of the status bits
  task automatic protect();
    sw(8'hfc);
    waitIdle();
    status(8'h8c);
    wr(16'h0002, 8'h12, 8'h34, 0);
    waitIdle();
    cmd(8'h04);
    rd(16'h0001, 8'h55, 8'h66, 9);
    @(posedge ref_clk);
    #1 protectPin_b = 1'b0;
    sw(8'h00);
    waitIdle();
    status(8'h8e);
    @(posedge ref_clk);
    #1 protectPin_b = 1'b1;
    sw(8'h00);
    waitIdle();
    status(8'h00);
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, about 80000 system clocks
  initial begin
    #320000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  // Main sequence
  initial begin
    miscompares     = 0;
    samples_checked = 0;
    rst_b           = 1'b0;
    protectPin_b    = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    latchCmds();
    pageWrite();
    aborts();
    protect();
    stop_test();
  end
endmodule
